// File: verilog/fis_pkg.sv
// Shared constants and types for the scalar floating-point issue and
// scoreboard timing block.
// Assumes one core clock; every figure is in execution cycles.
`default_nettype none

package fis_pkg;

  // ********************************************************************
  // sizes
  // ********************************************************************
  localparam int REG_W    = 5;          // register index width
  localparam int NUM_REGS = 32;         // double registers tracked
  localparam int CNT_W    = 5;          // countdown width, holds 25

  // ********************************************************************
  // instruction classes
  // ********************************************************************
  typedef enum logic [3:0] {
    OP_FP_ADD_SUB      = 4'h0,          // add or subtract
    OP_FP_CONVERT      = 4'h1,          // convert
    OP_FP_MULTIPLY     = 4'h2,          // multiply, negated multiply
    OP_FP_MULT_ACC     = 4'h3,          // all multiply-accumulate forms
    OP_FP_ABS_NEG      = 4'h4,          // absolute value, negate
    OP_FP_MOVE_TO_CORE = 4'h5,          // fp register to core register(s)
    OP_FP_STATUS_READ  = 4'h6,          // status/control register read
    OP_FP_MOVE_TO_FP   = 4'h7,          // core or fp register into fp
    OP_FP_MOVE_IMM     = 4'h8,          // immediate into fp register
    OP_FP_DIVIDE       = 4'h9           // divide
  } fis_op_t;

  // ********************************************************************
  // timing, in execution cycles counted from 1
  // ********************************************************************
  localparam logic [CNT_W-1:0] CYC_ONE       = 5'h01; // single cycle
  localparam logic [CNT_W-1:0] SRC_CYC       = 5'h01; // sources needed
  localparam logic [CNT_W-1:0] ADD_RES_CYC   = 5'h04; // add/sub/convert
  localparam logic [CNT_W-1:0] MUL_SP_RES    = 5'h05;
  localparam logic [CNT_W-1:0] MUL_DP_ISSUE  = 5'h02;
  localparam logic [CNT_W-1:0] MUL_DP_RES    = 5'h06;
  localparam logic [CNT_W-1:0] MAC_SP_RES    = 5'h08;
  localparam logic [CNT_W-1:0] MAC_DP_ISSUE  = 5'h02;
  localparam logic [CNT_W-1:0] MAC_DP_RES    = 5'h09;
  localparam logic [CNT_W-1:0] QUICK_WB_CYC  = 5'h02; // abs/neg/moves into fp
  localparam logic [CNT_W-1:0] DIV_SP_ISSUE  = 5'h0A;
  localparam logic [CNT_W-1:0] DIV_SP_RES    = 5'h0F;
  localparam logic [CNT_W-1:0] DIV_DP_ISSUE  = 5'h14;
  localparam logic [CNT_W-1:0] DIV_DP_RES    = 5'h19;
  localparam logic [CNT_W-1:0] ACC_FWD_CYC   = 5'h04; // matched chain
  localparam logic [CNT_W-1:0] ACC_MISM_CYC  = 5'h03; // mismatched chain

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [CNT_W-1:0] CNT_RST   = 5'h00;
  localparam logic [1:0]       TAG_RST   = 2'h0;
  localparam logic             READY_RST = 1'b1;
  localparam logic             FLAG_RST  = 1'b0;

endpackage : fis_pkg

`default_nettype wire

// File: verilog/fis_reg_track.sv
// Per-register scoreboard entry: counts down to the result and the
// writeback cycle of the last writer and remembers its kind.
// Assumes the issue logic only reloads it when the new writeback is later.
`timescale 1ns/1ns
`default_nettype none

module fis_reg_track
  import fis_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // writer issued this cycle
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] res_cyc,
  input  wire logic [CNT_W-1:0] wb_cyc,
  input  wire logic [1:0]       tag_in,
  // entry state
  output var  logic [CNT_W-1:0] rdy_cnt_r,
  output var  logic [CNT_W-1:0] wb_cnt_r,
  output var  logic [1:0]       tag_r,
  output var  logic             ready_r,
  output var  logic             commit_r
);

  // ********************************************************************
  // countdowns
  // ********************************************************************
  logic [CNT_W-1:0] rdy_nxt;            // cycles left to result
  logic [CNT_W-1:0] wb_nxt;             // cycles left to writeback
  localparam int    PEND_W = int'(DIV_DP_RES); // longest writeback span
  logic [PEND_W-1:0] pend_r;            // one bit per pending commit
  logic [PEND_W-1:0] pend_nxt;          // pending commits, next cycle

  // every writer keeps its own commit slot, so a later writer to the
  // same register cannot swallow an earlier writeback pulse
  assign pend_nxt = (pend_r >> 1) |
                    (load ? (PEND_W'(1'b1) << (wb_cyc - CYC_ONE)) :
                            PEND_W'(FLAG_RST));

  // exec cycle 1 is the cycle after issue, so load one less
  assign rdy_nxt = load ? res_cyc - CYC_ONE :
                   (rdy_cnt_r != CNT_RST) ? rdy_cnt_r - CYC_ONE : CNT_RST;
  assign wb_nxt  = load ? wb_cyc - CYC_ONE :
                   (wb_cnt_r != CNT_RST) ? wb_cnt_r - CYC_ONE : CNT_RST;

  // entry registers; the countdowns follow the latest writer only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdy_cnt_r <= CNT_RST;
      wb_cnt_r  <= CNT_RST;
      tag_r     <= TAG_RST;
      ready_r   <= READY_RST;
      commit_r  <= FLAG_RST;
      pend_r    <= PEND_W'(FLAG_RST);
    end else begin
      pend_r    <= pend_nxt;
      rdy_cnt_r <= rdy_nxt;
      wb_cnt_r  <= wb_nxt;
      tag_r     <= load ? tag_in : tag_r;
      ready_r   <= (rdy_nxt == CNT_RST);
      commit_r  <= pend_nxt[0];
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_rdy_before_wb;
    @(posedge mclk) disable iff (!resetn)
    rdy_cnt_r <= wb_cnt_r;
  endproperty
  a_rdy_before_wb: assert property (p_rdy_before_wb)
    else $error("result ready later than writeback");

  property p_add_commit;
    @(posedge mclk) disable iff (!resetn)
    (load && wb_cyc == ADD_RES_CYC) |-> ##4 commit_r;
  endproperty
  a_add_commit: assert property (p_add_commit)
    else $error("add writeback not at cycle 4");

  property p_mul_commit;
    @(posedge mclk) disable iff (!resetn)
    (load && wb_cyc == MUL_SP_RES) |=> !commit_r [*4] ##1 commit_r;
  endproperty
  a_mul_commit: assert property (p_mul_commit)
    else $error("multiply writeback not at cycle 5");

  property p_div_commit;
    @(posedge mclk) disable iff (!resetn)
    (load && wb_cyc == DIV_SP_RES) |-> ##15 commit_r;
  endproperty
  a_div_commit: assert property (p_div_commit)
    else $error("divide writeback not at cycle 15");

  property p_quick_ready;
    @(posedge mclk) disable iff (!resetn)
    (load && res_cyc == CYC_ONE) |=> ready_r ##1 commit_r;
  endproperty
  a_quick_ready: assert property (p_quick_ready)
    else $error("quick result not ready at 1 or committed at 2");

endmodule : fis_reg_track

`default_nettype wire

// File: verilog/fis_issue_sb.sv
// Issue gate and scoreboard for the scalar floating-point pipeline.
// Assumes the host holds a request until issue_ack is high, and in that
// cycle already presents its next request or drops req_valid.
`timescale 1ns/1ns
`default_nettype none

module fis_issue_sb
  import fis_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // issue request from the host
  input  wire logic                req_valid,
  input  wire fis_op_t             req_op,
  input  wire logic                req_dbl,
  input  wire logic [REG_W-1:0]    req_dst,
  input  wire logic [REG_W-1:0]    req_src_a,
  input  wire logic                req_src_a_quad,
  input  wire logic [REG_W-1:0]    req_src_b,
  input  wire logic                req_src_b_quad,
  // issue answer
  output logic                     issue_ack,
  output logic                     hazard_stall,
  output logic                     pipe_busy,
  // per-register state
  output logic [NUM_REGS-1:0]      fwd_ready,
  output logic [NUM_REGS-1:0]      commit
);

  // ********************************************************************
  // timing decode
  // ********************************************************************

  // issue cycles per class; precision ignored where untyped
  function automatic logic [CNT_W-1:0] f_issue(fis_op_t op, logic dbl);
    case (op)
      OP_FP_MULTIPLY: f_issue = dbl ? MUL_DP_ISSUE : CYC_ONE;
      OP_FP_MULT_ACC: f_issue = dbl ? MAC_DP_ISSUE : CYC_ONE;
      OP_FP_DIVIDE:   f_issue = dbl ? DIV_DP_ISSUE : DIV_SP_ISSUE;
      default:        f_issue = CYC_ONE;
    endcase
  endfunction : f_issue

  // result cycle per class
  function automatic logic [CNT_W-1:0] f_result(fis_op_t op, logic dbl);
    case (op)
      OP_FP_ADD_SUB,
      OP_FP_CONVERT:  f_result = ADD_RES_CYC;
      OP_FP_MULTIPLY: f_result = dbl ? MUL_DP_RES : MUL_SP_RES;
      OP_FP_MULT_ACC: f_result = dbl ? MAC_DP_RES : MAC_SP_RES;
      OP_FP_DIVIDE:   f_result = dbl ? DIV_DP_RES : DIV_SP_RES;
      default:        f_result = CYC_ONE;
    endcase
  endfunction : f_result

  // writeback cycle; the quick classes commit one after their result
  function automatic logic [CNT_W-1:0] f_wback(fis_op_t op, logic dbl);
    case (op)
      OP_FP_ABS_NEG,
      OP_FP_MOVE_TO_FP,
      OP_FP_MOVE_IMM: f_wback = QUICK_WB_CYC;
      default:        f_wback = f_result(op, dbl);
    endcase
  endfunction : f_wback

  // classes that write an fp register; core moves write none
  function automatic logic f_writes(fis_op_t op);
    case (op)
      OP_FP_MOVE_TO_CORE,
      OP_FP_STATUS_READ: f_writes = 1'b0;
      default:           f_writes = 1'b1;
    endcase
  endfunction : f_writes

  // classes reading a first fp source operand
  function automatic logic f_uses_a(fis_op_t op);
    case (op)
      OP_FP_STATUS_READ,
      OP_FP_MOVE_IMM: f_uses_a = 1'b0;
      default:        f_uses_a = 1'b1;
    endcase
  endfunction : f_uses_a

  // classes reading a second fp source operand
  function automatic logic f_uses_b(fis_op_t op);
    case (op)
      OP_FP_ADD_SUB,
      OP_FP_MULTIPLY,
      OP_FP_MULT_ACC,
      OP_FP_DIVIDE:   f_uses_b = 1'b1;
      default:        f_uses_b = 1'b0;
    endcase
  endfunction : f_uses_b

  // an operand arriving rem cycles ahead is in time for cycle need
  function automatic logic f_in_time(logic [CNT_W-1:0] rem,
                                     logic [CNT_W-1:0] need);
    f_in_time = (rem <= need);
  endfunction : f_in_time

  // ********************************************************************
  // scoreboard entries
  // ********************************************************************
  logic [CNT_W-1:0] rdy_cnt [NUM_REGS];  // cycles to forwardable result
  logic [CNT_W-1:0] wb_cnt  [NUM_REGS];  // cycles to writeback
  logic [1:0]       tag     [NUM_REGS];  // {multiply family, double}
  logic [NUM_REGS-1:0] load;             // entry written by this issue
  logic             issue_now;           // request taken at this edge
  logic [CNT_W-1:0] issue_cyc;           // decoded issue cycles
  logic [CNT_W-1:0] res_cyc;             // decoded result cycle
  logic [CNT_W-1:0] wb_cyc;              // decoded writeback cycle
  logic [1:0]       tag_new;             // kind of the issuing writer
  logic             writes;              // issuing op writes req_dst

  // one entry per double register; quad halves are two entries
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_ent
      assign load[gi] = issue_now & writes &
                        (req_dst == REG_W'(gi));
      fis_reg_track u_ent (
        .mclk      (mclk),
        .resetn    (resetn),
        .load      (load[gi]),
        .res_cyc   (res_cyc),
        .wb_cyc    (wb_cyc),
        .tag_in    (tag_new),
        .rdy_cnt_r (rdy_cnt[gi]),
        .wb_cnt_r  (wb_cnt[gi]),
        .tag_r     (tag[gi]),
        .ready_r   (fwd_ready[gi]),
        .commit_r  (commit[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // hazard checks
  // ********************************************************************
  logic [REG_W-1:0] a_hi;                // upper half of quad source a
  logic [REG_W-1:0] b_hi;                // upper half of quad source b
  logic             via_wb;              // consumer reads register file
  logic             is_mac;              // accumulator read of req_dst
  logic             acc_match;           // same type and size chain
  logic [CNT_W-1:0] acc_need;            // accumulator need cycle
  logic [CNT_W-1:0] rem_a_lo;
  logic [CNT_W-1:0] rem_a_hi;
  logic [CNT_W-1:0] rem_b_lo;
  logic [CNT_W-1:0] rem_b_hi;
  logic             ok_src;              // every source in time
  logic             ok_acc;              // accumulator in time
  logic             ok_waw;              // writeback stays in order
  logic [CNT_W-1:0] busy_r;              // issue cycles still held
  logic [CNT_W-1:0] busy_nxt;

  assign issue_cyc = f_issue(req_op, req_dbl);
  assign res_cyc   = f_result(req_op, req_dbl);
  assign wb_cyc    = f_wback(req_op, req_dbl);
  assign writes    = f_writes(req_op);
  assign is_mac    = (req_op == OP_FP_MULT_ACC);
  assign tag_new   = {is_mac | (req_op == OP_FP_MULTIPLY), req_dbl};
  assign a_hi      = req_src_a + REG_W'(1);
  assign b_hi      = req_src_b + REG_W'(1);

  // values bound for core registers have no forwarding path
  assign via_wb   = (req_op == OP_FP_MOVE_TO_CORE);
  assign rem_a_lo = via_wb ? wb_cnt[req_src_a] : rdy_cnt[req_src_a];
  assign rem_a_hi = via_wb ? wb_cnt[a_hi]      : rdy_cnt[a_hi];
  assign rem_b_lo = via_wb ? wb_cnt[req_src_b] : rdy_cnt[req_src_b];
  assign rem_b_hi = via_wb ? wb_cnt[b_hi]      : rdy_cnt[b_hi];

  // each half checked on its own entry
  assign ok_src = (!f_uses_a(req_op) | f_in_time(rem_a_lo, SRC_CYC)) &
                  (!f_uses_a(req_op) | !req_src_a_quad |
                   f_in_time(rem_a_hi, SRC_CYC)) &
                  (!f_uses_b(req_op) | f_in_time(rem_b_lo, SRC_CYC)) &
                  (!f_uses_b(req_op) | !req_src_b_quad |
                   f_in_time(rem_b_hi, SRC_CYC));

  // special multiplier-accumulator path only for a matched chain
  assign acc_match = tag[req_dst][1] & (tag[req_dst][0] == req_dbl);
  assign acc_need  = acc_match ? ACC_FWD_CYC : ACC_MISM_CYC;
  assign ok_acc    = !is_mac | f_in_time(rdy_cnt[req_dst], acc_need);

  // new writeback must land strictly after the pending one
  assign ok_waw = !writes | (wb_cnt[req_dst] < wb_cyc);

  // nothing issues while a multi-cycle op holds the pipe
  assign issue_now = req_valid & (busy_r == CNT_RST) &
                     ok_src & ok_acc & ok_waw;
  assign busy_nxt  = issue_now ? issue_cyc - CYC_ONE :
                     (busy_r != CNT_RST) ? busy_r - CYC_ONE : CNT_RST;

  // ********************************************************************
  // issue registers
  // ********************************************************************

  // answer flags registered so the host sees clean levels
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_r       <= CNT_RST;
      issue_ack    <= FLAG_RST;
      hazard_stall <= FLAG_RST;
      pipe_busy    <= FLAG_RST;
    end else begin
      busy_r       <= busy_nxt;
      issue_ack    <= issue_now;
      hazard_stall <= req_valid & !issue_now;
      pipe_busy    <= (busy_nxt != CNT_RST);
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  logic [CNT_W-1:0] gap_r;               // cycles since last issue
  logic [CNT_W-1:0] last_n_r;            // issue cycles of last issue

  // helper spacing counter, saturating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_r    <= DIV_DP_RES;
      last_n_r <= CYC_ONE;
    end else if (issue_now) begin
      gap_r    <= CYC_ONE;
      last_n_r <= issue_cyc;
    end else if (gap_r != DIV_DP_RES) begin
      gap_r    <= gap_r + CYC_ONE;
    end
  end

  property p_issue_spacing;
    @(posedge mclk) disable iff (!resetn)
    issue_now |-> (gap_r >= last_n_r);
  endproperty
  a_issue_spacing: assert property (p_issue_spacing)
    else $error("issue before previous issue cycles elapsed");

  property p_div_hold;
    @(posedge mclk) disable iff (!resetn)
    (issue_now && req_op == OP_FP_DIVIDE) |=>
      (pipe_busy && !issue_now) [*8];
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("issue during divide occupancy");

  property p_src_late;
    @(posedge mclk) disable iff (!resetn)
    (f_uses_a(req_op) && rem_a_lo > SRC_CYC) |-> !issue_now;
  endproperty
  a_src_late: assert property (p_src_late)
    else $error("issued before first source available");

  property p_core_waits;
    @(posedge mclk) disable iff (!resetn)
    (issue_now && via_wb) |-> (wb_cnt[req_src_a] <= SRC_CYC);
  endproperty
  a_core_waits: assert property (p_core_waits)
    else $error("core move issued before writeback");

  property p_in_order_wb;
    @(posedge mclk) disable iff (!resetn)
    (issue_now && writes) |=> (wb_cnt[$past(req_dst)] ==
                              $past(wb_cyc) - CYC_ONE);
  endproperty
  a_in_order_wb: assert property (p_in_order_wb)
    else $error("writeback order lost on reissue");

  property p_mul_chain;
    @(posedge mclk) disable iff (!resetn)
    (issue_now && req_op == OP_FP_MULTIPLY && !req_dbl) |=>
      (rdy_cnt[$past(req_dst)] == ACC_FWD_CYC);
  endproperty
  a_mul_chain: assert property (p_mul_chain)
    else $error("matched chain cannot issue back to back");

  property p_mism_chain;
    @(posedge mclk) disable iff (!resetn)
    (is_mac && !acc_match && rdy_cnt[req_dst] > ACC_MISM_CYC) |->
      !issue_now;
  endproperty
  a_mism_chain: assert property (p_mism_chain)
    else $error("mismatched chain issued before cycle 3");

endmodule : fis_issue_sb

`default_nettype wire

// File: bench/fis_host_model.sv
// Host issue stage model: presents one request at a time and holds it
// until the block acknowledges it. Assumes the testbench calls send/idle
// just after a rising edge of mclk.
`timescale 1ns/1ns
`default_nettype none

module fis_host_model
  import fis_pkg::*;
(
  // clock and answer
  input  wire logic             mclk,
  input  wire logic             issue_ack,
  input  wire logic             hazard_stall,
  // request
  output var  logic             req_valid,
  output var  fis_op_t          req_op,
  output var  logic             req_dbl,
  output var  logic [REG_W-1:0] req_dst,
  output var  logic [REG_W-1:0] req_src_a,
  output var  logic             req_src_a_quad,
  output var  logic [REG_W-1:0] req_src_b,
  output var  logic             req_src_b_quad
);
  int cyc = 0;  // free cycle count, stamps each acknowledge
  logic [REG_W-1:0] b_sel = 5'h00; // second source for later sends
  logic bq_sel = 1'b0;             // second source is a quad
  int hz;       // refused cycles seen on the last request

  // ********************************************************************
  // idle at time zero
  // ********************************************************************
  initial begin
    req_valid = 1'b0;
    req_op = OP_FP_ADD_SUB;
    req_dbl = 1'b0;
    req_dst = 5'h00;
    req_src_a = 5'h00;
    req_src_a_quad = 1'b0;
    req_src_b = 5'h00;
    req_src_b_quad = 1'b0;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // hold the request until acknowledged; in the ack cycle the caller
  // must present the next one or call idle, else it issues twice
  task automatic send(input fis_op_t op, input logic dbl,
                      input logic [REG_W-1:0] d, a, input logic q,
                      output int at);
    int n;
    req_valid <= 1'b1;
    req_op <= op;
    req_dbl <= dbl;
    req_dst <= d;
    req_src_a <= a;
    req_src_a_quad <= q;
    req_src_b <= b_sel;
    req_src_b_quad <= bq_sel;
    n = 0;
    hz = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (hazard_stall === 1'b1) hz++;
    end while (issue_ack !== 1'b1 && n < 40);
    at = cyc;
  endtask : send

  // released register numbers show the inverse so stale values never look valid
  task automatic idle;
    req_valid <= 1'b0;
    req_dst <= ~req_dst;
    req_src_a <= ~req_src_a;
    req_src_b <= ~req_src_b;
  endtask : idle
endmodule : fis_host_model

`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the issue and scoreboard block.
// Assumes the host model drives requests; source b is register 0 unless
// a scenario picks another one through the host.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import fis_pkg::*;
;
  logic mclk = 1'b0;   // 10 MHz core clock
  logic resetn = 1'b0; // active-low reset
  logic req_valid, req_dbl, qa, ack, hz, busy;
  fis_op_t op;
  logic [4:0] dst, sa, sb;
  logic qb;
  logic [31:0] fwd, cmt;
  int err_count = 0;
  int n_tests = 0;

  // ********************************************************************
  // clock, block and host
  // ********************************************************************
  initial forever #50 mclk = ~mclk;

  fis_issue_sb dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid),
    .req_op(op), .req_dbl(req_dbl), .req_dst(dst), .req_src_a(sa),
    .req_src_a_quad(qa), .req_src_b(sb), .req_src_b_quad(qb),
    .issue_ack(ack), .hazard_stall(hz), .pipe_busy(busy),
    .fwd_ready(fwd), .commit(cmt));

  fis_host_model host (.mclk(mclk), .issue_ack(ack), .hazard_stall(hz),
    .req_valid(req_valid), .req_op(op), .req_dbl(req_dbl),
    .req_dst(dst), .req_src_a(sa), .req_src_a_quad(qa),
    .req_src_b(sb), .req_src_b_quad(qb));

  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // one op alone: ack, busy span, forward and commit cycles
  task automatic run_op(fis_op_t o, logic b, logic [4:0] d, int n, r, w);
    int at;
    host.send(o, b, d, 5'h00, 1'b0, at);
    host.idle();
    for (int c = 1; c <= w + 1; c++) begin
      check("issue_ack", c == 1, ack);
      check("pipe_busy", c < n, busy);
      check("fwd_ready", c >= r, fwd[d]);
      check("commit", c == w, cmt[d]);
      @(posedge mclk);
      #1;
    end
  endtask : run_op

  // two requests presented back to back; k = spacing of the takes
  task automatic pair(fis_op_t o1, logic b1, logic [4:0] d1,
                      fis_op_t o2, logic b2, logic [4:0] d2,
                      logic [4:0] a2, logic q2, int k);
    int t1, t2;
    host.send(o1, b1, d1, 5'h00, 1'b0, t1);
    host.send(o2, b2, d2, a2, q2, t2);
    host.idle();
    check("take spacing", k, t2 - t1);
    check("hazard_stall count", k - 1, host.hz);
    repeat (30) @(posedge mclk);
    #1;
  endtask : pair

  // second operand path: a quad source b waits on its upper half
  task automatic src_b_wait;
    host.b_sel = 5'h14;
    host.bq_sel = 1'b1;
    pair(OP_FP_ADD_SUB, 0, 5'h15, OP_FP_ADD_SUB, 0, 5'h16, 0, 0, 3);
    host.b_sel = 5'h00;
    host.bq_sel = 1'b0;
  endtask : src_b_wait

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check("fwd_ready reset", 32'hFFFFFFFF, fwd);
    check("issue_ack reset", 0, ack);
    run_op(OP_FP_ADD_SUB, 1'b0, 5'h01, 1, 4, 4);
    run_op(OP_FP_CONVERT, 1'b1, 5'h02, 1, 4, 4);
    run_op(OP_FP_MULTIPLY, 1'b0, 5'h03, 1, 5, 5);
    run_op(OP_FP_MULTIPLY, 1'b1, 5'h04, 2, 6, 6);
    run_op(OP_FP_MULT_ACC, 1'b0, 5'h05, 1, 8, 8);
    run_op(OP_FP_MULT_ACC, 1'b1, 5'h06, 2, 9, 9);
    run_op(OP_FP_ABS_NEG, 1'b1, 5'h07, 1, 1, 2);
    run_op(OP_FP_MOVE_TO_FP, 1'b0, 5'h08, 1, 1, 2);
    run_op(OP_FP_MOVE_IMM, 1'b1, 5'h09, 1, 1, 2);
    run_op(OP_FP_DIVIDE, 1'b0, 5'h0A, 10, 15, 15);
    run_op(OP_FP_DIVIDE, 1'b1, 5'h0B, 20, 25, 25);
    pair(OP_FP_ADD_SUB, 0, 5'h03, OP_FP_ADD_SUB, 0, 5'h05, 5'h03, 0, 3);
    pair(OP_FP_ADD_SUB, 0, 5'h07, OP_FP_ADD_SUB, 0, 5'h0C, 5'h06, 1, 3);
    pair(OP_FP_ADD_SUB, 0, 5'h07, OP_FP_ADD_SUB, 0, 5'h0C, 5'h06, 0, 1);
    pair(OP_FP_MULTIPLY, 0, 5'h0A, OP_FP_MULT_ACC, 0, 5'h0A, 0, 0, 1);
    pair(OP_FP_MULTIPLY, 1, 5'h0B, OP_FP_MULT_ACC, 0, 5'h0B, 0, 0, 3);
    pair(OP_FP_DIVIDE, 0, 5'h0D, OP_FP_ABS_NEG, 0, 5'h0D, 0, 0, 14);
    pair(OP_FP_DIVIDE, 1, 5'h0E, OP_FP_ADD_SUB, 0, 5'h0F, 0, 0, 20);
    pair(OP_FP_ADD_SUB, 0, 5'h10, OP_FP_MOVE_TO_CORE, 0, 0, 5'h10, 0, 3);
    pair(OP_FP_ADD_SUB, 0, 5'h11, OP_FP_STATUS_READ, 0, 0, 5'h11, 0, 1);
    pair(OP_FP_MULTIPLY, 1, 5'h12, OP_FP_ADD_SUB, 0, 5'h13, 0, 0, 2);
    src_b_wait();
    results();
  end

  // hang guard: the whole sequence needs well under 1500 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    results();
  end
endmodule : testbench

`default_nettype wire
